// [src/intc_pkg.sv]
package intc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_NMI_POLL = 8'h16;
  localparam logic [7:0] IDX_GROUP_POLL = 8'h17;
  localparam logic [7:0] IDX_NMI_ENABLE = 8'h18;
  localparam logic [7:0] IDX_ENABLE_A = 8'h19;
  localparam logic [7:0] IDX_ENABLE_B = 8'h1A;
  localparam logic [7:0] IDX_ENABLE_C = 8'h1B;
  localparam logic [7:0] IDX_REQ_A = 8'h1C;
  localparam logic [7:0] IDX_REQ_B = 8'h1D;
  localparam logic [7:0] IDX_REQ_C = 8'h1E;
  localparam logic [7:0] IDX_TRIGGER = 8'h1F;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Group widths
  localparam int NMI_W = 2;
  localparam int DDC_W = 6;
  localparam int MISC_W = 4;
  // Field positions
  localparam int BIT_EXT_ZERO = 1;
  localparam int BIT_MUTE = 0;
  localparam int BIT_ADC = 3;
  localparam int BIT_VSYNC = 2;
  localparam int BIT_EXT_ONE = 1;
  localparam int BIT_TIMER = 0;
  localparam int BIT_EDGE_ZERO = 0;
  localparam int BIT_EDGE_ONE = 1;
  // Reset value and timer wrap ends
  localparam logic [7:0] TRIGGER_RESET = 8'hFF;
  localparam logic [7:0] TIMER_TOP = 8'hFF;
  localparam logic [7:0] TIMER_WRAP = 8'h00;
  // Vectors
  localparam logic [15:0] NMI_VEC_LO = 16'hFFFA;
  localparam logic [15:0] NMI_VEC_HI = 16'hFFFB;
  localparam logic [15:0] IRQ_VEC_LO = 16'hFFFE;
  localparam logic [15:0] IRQ_VEC_HI = 16'hFFFF;
  // Stack byte selects
  localparam logic [1:0] PUSH_PC_HI = 2'h0;
  localparam logic [1:0] PUSH_PC_LO = 2'h1;
  localparam logic [1:0] PUSH_STATUS = 2'h2;

  typedef enum logic [2:0] {
    seq_idle, seq_push_hi, seq_push_lo, seq_push_status, seq_vec_lo,
    seq_vec_hi
  } seq_state_type;
endpackage

// [src/edge_catch.sv]
`timescale 1ns/10ps
module edge_catch (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic rise_sel,
  output logic edge_pulse
);
  logic meta_r, sync_r, hold_r, level_r, primed_r;
  logic [2:0] fill_r;
  wire agree = (sync_r == hold_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hold_r <= 1'b0;
      level_r <= 1'b0;
      primed_r <= 1'b0;
      fill_r <= 3'h0;
      edge_pulse <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      hold_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
      // Prime only once the pipe holds pin samples: a level at reset is no edge
      if (agree && fill_r[2]) begin
        level_r <= hold_r;
        primed_r <= 1'b1;
      end
      edge_pulse <= agree && primed_r && (hold_r != level_r) &&
        (hold_r == rise_sel); // see RULE22
    end
  end

  chk_edge_single_pulse: assert property (@(posedge ref_clk) // see RULE22
    disable iff (!rst_n) edge_pulse |=> !edge_pulse)
    else $error("edge pulse lasted more than one cycle");
endmodule

// [src/req_group.sv]
`timescale 1ns/10ps
module req_group #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clear_vec,
  input wire logic [WIDTH-1:0] enable_vec,
  output logic [WIDTH-1:0] flags,
  output logic summary,
  output logic active
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          flags[i] <= 1'b0;
        end else if (set_vec[i]) begin
          flags[i] <= 1'b1; // see RULE17
        end else if (clear_vec[i]) begin
          flags[i] <= 1'b0; // see RULE19
        end
      end
    end
  endgenerate

  assign summary = |flags; // see RULE18
  assign active = |(flags & enable_vec); // see RULE21

  chk_set_beats_clear: assert property (@(posedge ref_clk) // see RULE19
    disable iff (!rst_n) |(set_vec & clear_vec) |=> |flags)
    else $error("clear won over a simultaneous set");
endmodule

// [src/intc_top.sv]
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - Enabled non-maskable requests reach the core whatever the mask flag.
// RULE2 - Maskable requests are held off while the core mask flag is set.
// RULE3 - Pending unmasked request starts a sequence pushing PC and status.
// RULE4 - The mask flag is driven high during the interrupt sequence.
// RULE5 - Maskable sequence ends fetching the vector at FFFE then FFFF.
// RULE6 - Non-maskable sequence fetches the vector at FFFA and FFFB.
// RULE7 - Non-maskable group is external edge zero and auto-mute only.
// RULE8 - Group A holds the six channel-0 serial channel sources.
// RULE9 - Group B holds the six channel-1 serial channel sources.
// RULE10 - Group C holds ADC done, vsync, external one and timer overflow.
// RULE11 - External zero flags on the edge chosen by its edge select.
// RULE12 - Auto-mute flags when the sync processor reports a mute.
// RULE13 - ADC done flags when a software-started conversion completes.
// RULE14 - Vsync flags on every rising edge.
// RULE15 - External one flags on the edge chosen by its edge select.
// RULE16 - Timer flags whenever the base counter wraps from FF to 00.
// RULE17 - Request flags set on trigger regardless of enable bits.
// RULE18 - Group summary follows any member flag and clears with them.
// RULE19 - Writing one clears a flag, zero leaves it; uncleared re-interrupts. Uncleared non-maskable flags do not; only a rise of nmi_request is latched.
// RULE20 - Edge selects reset to one (rising); zero selects falling.
// RULE21 - A request line rises only for a flagged and enabled source.
// RULE22 - Pin edges are synchronised and flag exactly once.
module intc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [intc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [intc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [intc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_zero_pin,
  input wire logic ext_one_pin,
  input wire logic vsync_pin,
  input wire logic mute_pin,
  input wire logic ch0_clock_low_event,
  input wire logic ch0_addr_match_event,
  input wire logic ch0_tx_empty_event,
  input wire logic ch0_rx_full_event,
  input wire logic ch0_no_ack_event,
  input wire logic ch0_stop_event,
  input wire logic ch1_clock_low_event,
  input wire logic ch1_addr_match_event,
  input wire logic ch1_tx_empty_event,
  input wire logic ch1_rx_full_event,
  input wire logic ch1_no_ack_event,
  input wire logic ch1_stop_event,
  input wire logic conversion_start_n,
  input wire logic adc_conv_complete,
  input wire logic [7:0] base_timer_count,
  input wire logic cpu_mask_flag,
  input wire logic cpu_instr_end,
  output logic nmi_request,
  output logic irq_request,
  output logic maskable_group_a,
  output logic maskable_group_b,
  output logic maskable_group_c,
  output logic seq_active,
  output logic mask_flag_set,
  output logic stack_push,
  output logic [1:0] stack_select,
  output logic vector_read,
  output logic [15:0] vector_addr,
  output logic pc_load
);
  import intc_pkg::*;

  logic [NMI_W-1:0] nmi_en_r, nmi_flags, nmi_set, nmi_clr;
  logic [DDC_W-1:0] a_en_r, a_flags, a_set, a_clr;
  logic [DDC_W-1:0] b_en_r, b_flags, b_set, b_clr;
  logic [MISC_W-1:0] c_en_r, c_flags, c_set, c_clr;
  logic [7:0] trigger_r, timer_prev_r;
  logic ack_r, conv_pending_r, nmi_prev_r, nmi_pending_r, kind_nmi_r;
  logic [DATA_W-1:0] rd_data_r;
  logic nmi_summary, a_active, b_active, c_active;
  logic e0_edge, e1_edge, vs_edge, mute_edge;
  seq_state_type state_r, state_nxt;

  // Bus decode: one wait cycle on every access, so read data are registered
  wire access = avs_read | avs_write;
  wire take = access & ack_r;
  wire aligned = (avs_address[1:0] == 2'b00);
  wire [7:0] index = {2'b00, avs_address[7:2]};
  wire wr_take = take & avs_write & avs_byteenable[0] & aligned;
  wire [7:0] wdata = avs_writedata[7:0];
  wire wr_nmi_poll = wr_take & (index == IDX_NMI_POLL);
  wire wr_nmi_en = wr_take & (index == IDX_NMI_ENABLE);
  wire wr_en_a = wr_take & (index == IDX_ENABLE_A);
  wire wr_en_b = wr_take & (index == IDX_ENABLE_B);
  wire wr_en_c = wr_take & (index == IDX_ENABLE_C);
  wire wr_req_a = wr_take & (index == IDX_REQ_A);
  wire wr_req_b = wr_take & (index == IDX_REQ_B);
  wire wr_req_c = wr_take & (index == IDX_REQ_C);
  wire wr_trigger = wr_take & (index == IDX_TRIGGER);
  assign avs_waitrequest = access & ~ack_r;
  assign avs_readdata = rd_data_r;

  // Unmapped or misaligned reads return zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (aligned) begin
      unique case (index)
        IDX_NMI_POLL: rd_mux = {6'h00, nmi_flags};
        IDX_GROUP_POLL: rd_mux = {5'h00, maskable_group_c,
          maskable_group_b, maskable_group_a}; // see RULE18
        IDX_NMI_ENABLE: rd_mux = {6'h00, nmi_en_r};
        IDX_ENABLE_A: rd_mux = {2'h0, a_en_r};
        IDX_ENABLE_B: rd_mux = {2'h0, b_en_r};
        IDX_ENABLE_C: rd_mux = {4'h0, c_en_r};
        IDX_REQ_A: rd_mux = {2'h0, a_flags};
        IDX_REQ_B: rd_mux = {2'h0, b_flags};
        IDX_REQ_C: rd_mux = {4'h0, c_flags};
        IDX_TRIGGER: rd_mux = trigger_r;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ack_r <= access & ~ack_r;
      rd_data_r <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nmi_en_r <= '0;
      a_en_r <= '0;
      b_en_r <= '0;
      c_en_r <= '0;
      trigger_r <= TRIGGER_RESET; // see RULE20
    end else begin
      if (wr_nmi_en) nmi_en_r <= wdata[NMI_W-1:0];
      if (wr_en_a) a_en_r <= wdata[DDC_W-1:0];
      if (wr_en_b) b_en_r <= wdata[DDC_W-1:0];
      if (wr_en_c) c_en_r <= wdata[MISC_W-1:0];
      if (wr_trigger) trigger_r <= wdata;
    end
  end

  // Source capture
  edge_catch u_ext_zero (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(ext_zero_pin),
    .rise_sel(trigger_r[BIT_EDGE_ZERO]), .edge_pulse(e0_edge)); // see RULE11
  edge_catch u_ext_one (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(ext_one_pin),
    .rise_sel(trigger_r[BIT_EDGE_ONE]), .edge_pulse(e1_edge)); // see RULE15
  edge_catch u_vsync (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(vsync_pin),
    .rise_sel(1'b1), .edge_pulse(vs_edge)); // see RULE14
  edge_catch u_mute (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(mute_pin),
    .rise_sel(1'b1), .edge_pulse(mute_edge)); // see RULE12

  // A completion with no software start behind it is not reported
  wire adc_set = adc_conv_complete & conv_pending_r; // see RULE13
  wire timer_wrap = (timer_prev_r == TIMER_TOP) &&
    (base_timer_count == TIMER_WRAP); // see RULE16

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_pending_r <= 1'b0;
      timer_prev_r <= 8'h00;
    end else begin
      timer_prev_r <= base_timer_count;
      if (!conversion_start_n) conv_pending_r <= 1'b1;
      else if (adc_conv_complete) conv_pending_r <= 1'b0;
    end
  end

  always_comb begin
    nmi_set = '0;
    nmi_set[BIT_EXT_ZERO] = e0_edge; // see RULE7
    nmi_set[BIT_MUTE] = mute_edge;
    c_set = '0;
    c_set[BIT_ADC] = adc_set; // see RULE10
    c_set[BIT_VSYNC] = vs_edge;
    c_set[BIT_EXT_ONE] = e1_edge;
    c_set[BIT_TIMER] = timer_wrap;
  end
  assign a_set = {ch0_clock_low_event, ch0_addr_match_event,
    ch0_tx_empty_event, ch0_rx_full_event, ch0_no_ack_event,
    ch0_stop_event}; // see RULE8
  assign b_set = {ch1_clock_low_event, ch1_addr_match_event,
    ch1_tx_empty_event, ch1_rx_full_event, ch1_no_ack_event,
    ch1_stop_event}; // see RULE9
  assign nmi_clr = {NMI_W{wr_nmi_poll}} & wdata[NMI_W-1:0]; // see RULE19
  assign a_clr = {DDC_W{wr_req_a}} & wdata[DDC_W-1:0];
  assign b_clr = {DDC_W{wr_req_b}} & wdata[DDC_W-1:0];
  assign c_clr = {MISC_W{wr_req_c}} & wdata[MISC_W-1:0];

  req_group #(.WIDTH(NMI_W)) u_nmi_grp (
    .ref_clk(ref_clk), .rst_n(rst_n), .set_vec(nmi_set),
    .clear_vec(nmi_clr), .enable_vec(nmi_en_r), .flags(nmi_flags),
    .summary(nmi_summary), .active(nmi_request)); // see RULE1
  req_group #(.WIDTH(DDC_W)) u_grp_a (
    .ref_clk(ref_clk), .rst_n(rst_n), .set_vec(a_set),
    .clear_vec(a_clr), .enable_vec(a_en_r), .flags(a_flags),
    .summary(maskable_group_a), .active(a_active));
  req_group #(.WIDTH(DDC_W)) u_grp_b (
    .ref_clk(ref_clk), .rst_n(rst_n), .set_vec(b_set),
    .clear_vec(b_clr), .enable_vec(b_en_r), .flags(b_flags),
    .summary(maskable_group_b), .active(b_active));
  req_group #(.WIDTH(MISC_W)) u_grp_c (
    .ref_clk(ref_clk), .rst_n(rst_n), .set_vec(c_set),
    .clear_vec(c_clr), .enable_vec(c_en_r), .flags(c_flags),
    .summary(maskable_group_c), .active(c_active));

  wire irq_any = a_active | b_active | c_active; // see RULE21
  assign irq_request = irq_any & ~cpu_mask_flag; // see RULE2

  // Non-maskable is edge sensitive at the core, so its rise is latched
  wire nmi_rise = nmi_request & ~nmi_prev_r;
  wire seq_start = (state_r == seq_idle) & cpu_instr_end &
    (nmi_pending_r | irq_request); // see RULE3
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nmi_prev_r <= 1'b0;
      nmi_pending_r <= 1'b0;
      kind_nmi_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_request;
      if (nmi_rise) nmi_pending_r <= 1'b1; // see RULE1
      else if (seq_start & nmi_pending_r) nmi_pending_r <= 1'b0;
      if (seq_start) kind_nmi_r <= nmi_pending_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      seq_idle: if (seq_start) state_nxt = seq_push_hi;
      seq_push_hi: state_nxt = seq_push_lo;
      seq_push_lo: state_nxt = seq_push_status;
      seq_push_status: state_nxt = seq_vec_lo;
      seq_vec_lo: state_nxt = seq_vec_hi;
      seq_vec_hi: state_nxt = seq_idle;
    endcase
  end

  wire nxt_nmi = (state_r == seq_idle) ? nmi_pending_r : kind_nmi_r;
  wire nxt_push = (state_nxt == seq_push_hi) | (state_nxt == seq_push_lo) |
    (state_nxt == seq_push_status); // see RULE3
  wire nxt_vec = (state_nxt == seq_vec_lo) | (state_nxt == seq_vec_hi);
  wire [1:0] nxt_sel = (state_nxt == seq_push_hi) ? PUSH_PC_HI :
    (state_nxt == seq_push_lo) ? PUSH_PC_LO : PUSH_STATUS;
  wire [15:0] nxt_addr = (state_nxt == seq_vec_lo) ?
    (nxt_nmi ? NMI_VEC_LO : IRQ_VEC_LO) :
    (nxt_nmi ? NMI_VEC_HI : IRQ_VEC_HI); // see RULE5 see RULE6

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= seq_idle;
      seq_active <= 1'b0;
      mask_flag_set <= 1'b0;
      stack_push <= 1'b0;
      stack_select <= PUSH_PC_HI;
      vector_read <= 1'b0;
      vector_addr <= IRQ_VEC_LO;
      pc_load <= 1'b0;
    end else begin
      state_r <= state_nxt;
      seq_active <= (state_nxt != seq_idle);
      mask_flag_set <= (state_nxt != seq_idle); // see RULE4
      stack_push <= nxt_push;
      stack_select <= nxt_sel;
      vector_read <= nxt_vec;
      vector_addr <= nxt_addr;
      pc_load <= (state_nxt == seq_vec_hi);
    end
  end

  chk_nmi_ignores_mask: assert property (@(posedge ref_clk) // see RULE1
    disable iff (!rst_n) nmi_rise |=> nmi_pending_r || seq_active)
    else $error("enabled non-maskable rise not latched");
  chk_irq_mask_gate: assert property (@(posedge ref_clk) // see RULE2
    disable iff (!rst_n) (cpu_mask_flag && !nmi_pending_r) |-> !seq_start)
    else $error("maskable sequence started under a set mask flag");
  chk_push_three_bytes: assert property (@(posedge ref_clk) // see RULE3
    disable iff (!rst_n) seq_start |=> stack_push [*3] ##1 !stack_push)
    else $error("sequence did not push exactly three bytes");
  chk_mask_during_seq: assert property (@(posedge ref_clk) // see RULE4
    disable iff (!rst_n) seq_start |=> mask_flag_set [*5] ##1 !seq_active)
    else $error("mask flag not driven through the sequence");
  chk_irq_vector_pair: assert property (@(posedge ref_clk) // see RULE5
    disable iff (!rst_n) (seq_start && !nmi_pending_r) |=> ##3
    (vector_read && vector_addr == 16'hFFFE) ##1
    (pc_load && vector_addr == 16'hFFFF))
    else $error("maskable vector fetch wrong");
  chk_nmi_vector_pair: assert property (@(posedge ref_clk) // see RULE6
    disable iff (!rst_n) (seq_start && nmi_pending_r) |=> ##3
    (vector_addr == 16'hFFFA) ##1 (vector_addr == 16'hFFFB))
    else $error("non-maskable vector fetch wrong");
  chk_timer_flag_set: assert property (@(posedge ref_clk) // see RULE16
    disable iff (!rst_n) timer_wrap |=> c_flags[BIT_TIMER])
    else $error("timer wrap not flagged");
  chk_group_summary: assert property (@(posedge ref_clk) // see RULE18
    disable iff (!rst_n) ($fell(maskable_group_a) && $past(rst_n)) |->
    $past(wr_req_a))
    else $error("group summary fell without a member clear");
  chk_trigger_reset: assert property (@(posedge ref_clk) // see RULE20
    $rose(rst_n) |-> trigger_r == 8'hFF)
    else $error("edge selects not all ones after reset");
  chk_enable_request: assert property (@(posedge ref_clk) // see RULE21
    disable iff (!rst_n) irq_request |-> |(c_flags & c_en_r) ||
    |(a_flags & a_en_r) || |(b_flags & b_en_r))
    else $error("request line without enabled flag");
endmodule

// [tb/cpu_model.sv]
`timescale 1ns/10ps
module cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mask_release,
  input wire logic mask_flag_set,
  input wire logic stack_push,
  input wire logic [1:0] stack_select,
  input wire logic vector_read,
  input wire logic [15:0] vector_addr,
  input wire logic pc_load,
  output logic cpu_mask_flag,
  output logic cpu_instr_end,
  output logic [7:0] taken_cnt,
  output logic [15:0] vec_lo,
  output logic [15:0] vec_hi,
  output logic [5:0] push_trace
);
  logic [1:0] div_r;
  // Slow mode spaces instruction boundaries four cycles apart
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      cpu_instr_end <= 1'h0;
      // Core comes out of reset with maskable requests blocked
      cpu_mask_flag <= 1'h1;
      taken_cnt <= 8'h00;
      vec_lo <= 16'h0000;
      vec_hi <= 16'h0000;
      push_trace <= 6'h00;
    end else begin
      div_r <= div_r + 2'h1;
      cpu_instr_end <= !slow || (div_r == 2'h3);
      if (mask_flag_set) begin
        cpu_mask_flag <= 1'h1;
      end else if (mask_release) begin
        cpu_mask_flag <= 1'h0;
      end
      if (stack_push) begin
        push_trace <= {push_trace[3:0], stack_select};
      end
      if (vector_read && !pc_load) begin
        vec_lo <= vector_addr;
      end
      if (pc_load) begin
        vec_hi <= vector_addr;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
  end
endmodule

// [tb/tb_intc_top.sv]
`timescale 1ns/10ps
module tb_intc_top;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_zero_pin = 1'h0;
  logic ext_one_pin = 1'h0;
  logic vsync_pin = 1'h0;
  logic mute_pin = 1'h0;
  logic [5:0] ev_a = 6'h00;
  logic [5:0] ev_b = 6'h00;
  logic conversion_start_n = 1'h1;
  logic adc_conv_complete = 1'h0;
  logic [7:0] base_timer_count = 8'h10;
  logic slow = 1'h0;
  logic mask_release = 1'h0;
  logic cpu_mask_flag, cpu_instr_end, nmi_request, irq_request;
  logic maskable_group_a, maskable_group_b, maskable_group_c;
  logic seq_active, mask_flag_set, stack_push, vector_read, pc_load;
  logic [1:0] stack_select;
  logic [15:0] vector_addr, vec_lo, vec_hi;
  logic [7:0] taken_cnt;
  logic [5:0] push_trace;
  int n_errors = 0;
  int n_tests = 0;
  integer seed = 32'hDA19;
  logic [31:0] q, v;

  intc_top u_intc_top (.*,
    .ch0_clock_low_event(ev_a[5]), .ch0_addr_match_event(ev_a[4]),
    .ch0_tx_empty_event(ev_a[3]), .ch0_rx_full_event(ev_a[2]),
    .ch0_no_ack_event(ev_a[1]), .ch0_stop_event(ev_a[0]),
    .ch1_clock_low_event(ev_b[5]), .ch1_addr_match_event(ev_b[4]),
    .ch1_tx_empty_event(ev_b[3]), .ch1_rx_full_event(ev_b[2]),
    .ch1_no_ack_event(ev_b[1]), .ch1_stop_event(ev_b[0]));
  cpu_model u_cpu_model (.*);

  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] bit_of(input int i);
    return 32'h1 << i;
  endfunction

  function automatic logic [31:0] en_mask(input logic [7:0] a);
    return (a == 8'h60) ? 32'h3 : (a == 8'h6C) ? 32'hF : 32'h3F;
  endfunction

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 40);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (k >= 40) begin
      n_errors++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    check(q, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic pulse_ev(input int g, input int i);
    @(posedge ref_clk);
    if (g == 0) begin
      ev_a <= 6'h01 << i;
    end else begin
      ev_b <= 6'h01 << i;
    end
    @(posedge ref_clk);
    ev_a <= 6'h00;
    ev_b <= 6'h00;
  endtask

  task automatic pulse_adc;
    @(posedge ref_clk);
    adc_conv_complete <= 1'h1;
    @(posedge ref_clk);
    adc_conv_complete <= 1'h0;
  endtask

  task automatic release_mask;
    @(posedge ref_clk);
    mask_release <= 1'h1;
    @(posedge ref_clk);
    mask_release <= 1'h0;
  endtask

  // Bounded wait for the core model to finish a vector fetch
  task automatic wait_taken(input logic [7:0] n);
    int k;
    k = 0;
    while (taken_cnt !== n && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    check({24'h0, taken_cnt}, {24'h0, n});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  initial begin
    tick(8);
    rst_n <= 1'h1;
    tick(6);
    for (int a = 8'h58; a <= 8'h7C; a += 4) begin
      rd(a[7:0], (a == 8'h7C) ? 32'hFF : 32'h0);
    end
    rd(8'h80, 32'h0);
    rd(8'h59, 32'h0);
    $display("test reset values done");
    for (int a = 8'h60; a <= 8'h6C; a += 4) begin
      v = $random(seed);
      bus(1'h1, a[7:0], v);
      rd(a[7:0], v & en_mask(a[7:0]));
      avs_byteenable <= 4'h0;
      bus(1'h1, a[7:0], ~v);
      avs_byteenable <= 4'hF;
      rd(a[7:0], v & en_mask(a[7:0]));
      bus(1'h1, a[7:0], 32'h0);
    end
    $display("test enables done");
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 6; i++) begin
        pulse_ev(g, i);
        tick(1);
        check({31'h0, g ? maskable_group_b : maskable_group_a}, 32'h1);
        check({31'h0, irq_request}, 32'h0);
        rd(8'h70 + 4 * g, bit_of(i));
        rd(8'h5C, bit_of(g));
        bus(1'h1, 8'h70 + 4 * g, ~bit_of(i) & 32'h3F);
        rd(8'h70 + 4 * g, bit_of(i));
        bus(1'h1, 8'h70 + 4 * g, bit_of(i));
        rd(8'h70 + 4 * g, 32'h0);
        rd(8'h5C, 32'h0);
      end
    end
    $display("test serial channel groups done");
    base_timer_count <= $random(seed) % 8'hFF;
    tick(2);
    base_timer_count <= 8'hFF;
    tick(3);
    rd(8'h78, 32'h0);
    base_timer_count <= 8'h00;
    tick(2);
    rd(8'h78, 32'h1);
    bus(1'h1, 8'h78, 32'h1);
    pulse_adc();
    rd(8'h78, 32'h0);
    conversion_start_n <= 1'h0;
    tick(2);
    conversion_start_n <= 1'h1;
    pulse_adc();
    rd(8'h78, 32'h8);
    bus(1'h1, 8'h78, 32'h8);
    vsync_pin <= 1'h1;
    tick(8);
    rd(8'h78, 32'h4);
    bus(1'h1, 8'h78, 32'h4);
    vsync_pin <= 1'h0;
    tick(8);
    rd(8'h78, 32'h0);
    ext_one_pin <= 1'h1;
    tick(8);
    rd(8'h78, 32'h2);
    bus(1'h1, 8'h78, 32'h2);
    bus(1'h1, 8'h7C, 32'hFD);
    rd(8'h7C, 32'hFD);
    ext_one_pin <= 1'h0;
    tick(8);
    rd(8'h78, 32'h2);
    bus(1'h1, 8'h78, 32'h2);
    ext_one_pin <= 1'h1;
    tick(8);
    rd(8'h78, 32'h0);
    ext_zero_pin <= 1'h1;
    tick(8);
    rd(8'h58, 32'h2);
    bus(1'h1, 8'h58, 32'h2);
    bus(1'h1, 8'h7C, 32'hFC);
    ext_zero_pin <= 1'h0;
    tick(8);
    rd(8'h58, 32'h2);
    bus(1'h1, 8'h58, 32'h2);
    mute_pin <= 1'h1;
    tick(8);
    rd(8'h58, 32'h1);
    bus(1'h1, 8'h58, 32'h1);
    rd(8'h58, 32'h0);
    $display("test sources done");
    bus(1'h1, 8'h6C, 32'h1);
    base_timer_count <= 8'hFF;
    tick(2);
    base_timer_count <= 8'h00;
    tick(4);
    check({31'h0, irq_request}, 32'h0);
    check({31'h0, maskable_group_c}, 32'h1);
    check({24'h0, taken_cnt}, 32'h0);
    release_mask();
    wait_taken(8'h01);
    check({31'h0, seq_active}, 32'h0);
    check({16'h0, vec_lo}, 32'hFFFE);
    check({16'h0, vec_hi}, 32'hFFFF);
    check({26'h0, push_trace}, 32'h06);
    check({31'h0, cpu_mask_flag}, 32'h1);
    check({31'h0, irq_request}, 32'h0);
    slow <= 1'h1;
    release_mask();
    wait_taken(8'h02);
    bus(1'h1, 8'h78, 32'h1);
    release_mask();
    tick(20);
    check({24'h0, taken_cnt}, 32'h02);
    $display("test maskable sequence done");
    bus(1'h1, 8'h60, 32'h1);
    @(posedge ref_clk);
    mask_release <= 1'h0;
    mute_pin <= 1'h0;
    tick(8);
    rd(8'h58, 32'h0);
    mute_pin <= 1'h1;
    wait_taken(8'h03);
    check({16'h0, vec_lo}, 32'hFFFA);
    check({16'h0, vec_hi}, 32'hFFFB);
    bus(1'h1, 8'h58, 32'h1);
    tick(2);
    check({31'h0, nmi_request}, 32'h0);
    $display("test non-maskable sequence done");
    conclude();
  end
endmodule
